/* File: pkg/tlm_map.vh */
// Constants for the table, logic and math compute block.
// Assumes word-aligned AXI4-Lite access; offsets below are word indexes.
`ifndef TLM_MAP_VH
`define TLM_MAP_VH
`define TLM_CLK_NS   50
`define TLM_TICK_NS  1000000
`define TLM_NSIG     8
`define TLM_FS       10000
`define TLM_ONE      100
`define TLM_XMIN     -100000
`define TLM_XMAX     1000000
`define TLM_NPT      11
`define TLM_IX_X     0
`define TLM_IX_Y     33
`define TLM_IX_SH    66
`define TLM_IX_LCTL  99
`define TLM_IX_SEN   102
`define TLM_IX_CAND  103
`define TLM_IX_COND  106
`define TLM_IX_MSRC  115
`define TLM_IX_MMIN  121
`define TLM_IX_MMAX  127
`define TLM_IX_STG   133
`define TLM_IX_A1    137
`define TLM_IX_OLO   138
`define TLM_IX_OHI   139
`define TLM_NCFG     140
`define TLM_IX_LOUT  140
`define TLM_IX_SOUT  143
`define TLM_IX_MOUT  144
`define TLM_IX_YMIN  145
`define TLM_IX_YMAX  148
`define TLM_NREG     151
`define TLM_SH_IGN   2'h0
`define TLM_SH_RAMP  2'h1
`define TLM_SH_JUMP  2'h2
`define TLM_SRC_NONE 4'h0
`define TLM_SRC_LUT  4'h9
`define TLM_SRC_SEL  4'hc
`define TLM_SRC_MATH 4'hd
`define TLM_OP_OR    4'h6
`define TLM_OP_AND   4'h7
`define TLM_OP_XOR   4'h8
`define TLM_OP_ADD   4'h9
`define TLM_OP_SUB   4'ha
`define TLM_OP_MUL   4'hb
`define TLM_OP_DIV   4'hc
`define TLM_OP_MIN   4'hd
`define TLM_OP_MAX   4'he
`define TLM_RESP_OK  2'h0
`define TLM_RESP_ERR 2'h2
`endif

/* File: logic/tlm_core.v */
// Three lookup tables, a prioritised table selector and a four-stage
// math chain, configured over AXI4-Lite. Signal inputs are synchronous.
//
// How it works
// [RULE1] Each table gives up to ten segments from eleven ordered points.
// [RULE2] Axis kind 0 uses the input value, 1 selects time mode.
// [RULE3] Time mode: x is elapsed milliseconds, input is only an enable.
// [RULE4] Shape 0 ignores a point, 1 ramps, 2 jumps.
// [RULE5] Jump segment outputs this point's y for inputs in the segment.
// [RULE6] Point 0 shape is always jump; writes cannot change it.
// [RULE7] An ignored point hides itself and every later point.
// [RULE8] X writes bounded to -100000..1000000, or math range for math source.
// [RULE9] Software keeps x non-decreasing, editing the highest index first.
// [RULE10] Table output range is min and max y over live points.
// [RULE11] Selector works only when enabled; disabled after reset.
// [RULE12] Conditions compare with code 0..5: eq, ne, gt, ge, lt, le.
// [RULE13] Unused argument source reads as zero.
// [RULE14] Combine code 0 true, 1 all, 2 any, 3 (c1&c2)|c3, 4 (c1|c2)&c3.
// [RULE15] First satisfied candidate wins; none gives the first candidate.
// [RULE16] Six math inputs scaled to percent by their min and max.
// [RULE17] Four chained operators; later stages take the previous result.
// [RULE18] Unused right operand passes the left operand through.
// [RULE19] Operator codes: 0..5 compare, 6..8 logic, 9..12 arith, 13 min, 14 max.
// [RULE20] Logic true at one percent or more; compare and logic give 0 or 1.
// [RULE21] Division by zero gives full scale.
// [RULE22] Final percent mapped linearly onto output low and high.
// [RULE23] Arithmetic results clamped to zero..full scale.
// [RULE24] All outputs recomputed once per tick from that tick's inputs.
`timescale 1ns/10ps
`include "tlm_map.vh"

module tlm_core #(
    parameter TICK_CYC = `TLM_TICK_NS / `TLM_CLK_NS,
    parameter NSIG     = `TLM_NSIG
) (
    // Clock and reset
    input  wire                 aclk,
    input  wire                 aresetn,
    // AXI4-Lite write
    input  wire [9:0]           s_axi_awaddr,
    input  wire                 s_axi_awvalid,
    output reg                  s_axi_awready,
    input  wire [31:0]          s_axi_wdata,
    input  wire [3:0]           s_axi_wstrb,
    input  wire                 s_axi_wvalid,
    output reg                  s_axi_wready,
    output reg  [1:0]           s_axi_bresp,
    output reg                  s_axi_bvalid,
    input  wire                 s_axi_bready,
    // AXI4-Lite read
    input  wire [9:0]           s_axi_araddr,
    input  wire                 s_axi_arvalid,
    output reg                  s_axi_arready,
    output reg  [31:0]          s_axi_rdata,
    output reg  [1:0]           s_axi_rresp,
    output reg                  s_axi_rvalid,
    input  wire                 s_axi_rready,
    // Signal inputs, signed, one 32-bit word each
    input  wire [32*NSIG-1:0]   sig_in,
    // Results
    output reg  [95:0]          lut_value_q,
    output reg  [31:0]          sel_value_q,
    output reg  [31:0]          math_value_q,
    output reg                  update_q
);

    localparam signed [31:0] FS   = `TLM_FS;
    localparam signed [31:0] ONE  = `TLM_ONE;
    localparam signed [31:0] XMIN = `TLM_XMIN;
    localparam signed [31:0] XMAX = `TLM_XMAX;
    localparam [7:0] IX_X  = `TLM_IX_X;
    localparam [7:0] IX_Y  = `TLM_IX_Y;
    localparam [7:0] IX_SH = `TLM_IX_SH;
    localparam [7:0] NCFG  = `TLM_NCFG;
    localparam [7:0] NREG  = `TLM_NREG;
    localparam [31:0] TICK_LAST = TICK_CYC - 1;

    function cmp_rel;
        input [2:0]         op;
        input signed [31:0] a;
        input signed [31:0] b;
        begin
            case (op)
                3'h0:    cmp_rel = (a == b);
                3'h1:    cmp_rel = (a != b);
                3'h2:    cmp_rel = (a > b);
                3'h3:    cmp_rel = (a >= b);
                3'h4:    cmp_rel = (a < b);
                3'h5:    cmp_rel = (a <= b);
                default: cmp_rel = 1'b0;
            endcase
        end
    endfunction

    function [31:0] clamp_fs;
        input signed [63:0] v;
        begin
            if (v < 0)
                clamp_fs = 32'h0;
            else if (v > FS)
                clamp_fs = FS;
            else
                clamp_fs = v[31:0];
        end
    endfunction

    reg  [31:0] cfg_q [0:`TLM_NCFG-1];
    reg  [31:0] tick_cnt_q;
    wire        tick = (tick_cnt_q == TICK_LAST);

    always @(posedge aclk) begin
        if (!aresetn || tick)
            tick_cnt_q <= 32'h0;
        else
            tick_cnt_q <= tick_cnt_q + 32'h1;
    end

    // Sources read the previous tick's results so no loop can form
    // [RULE13] unused reads zero
    wire [31:0] src_v [0:15];
    assign src_v[0] = 32'h0;
    genvar gs;
    generate
        for (gs = 1; gs < 16; gs = gs + 1) begin : g_src
            if (gs <= NSIG && gs < 9) begin : g_sig
                assign src_v[gs] = sig_in[32*(gs-1) +: 32];
            end else if (gs >= 9 && gs < 12) begin : g_lut
                assign src_v[gs] = lut_value_q[32*(gs-9) +: 32];
            end else if (gs == 12) begin : g_sel
                assign src_v[gs] = sel_value_q;
            end else if (gs == 13) begin : g_math
                assign src_v[gs] = math_value_q;
            end else begin : g_zero
                assign src_v[gs] = 32'h0;
            end
        end
    endgenerate

    wire [95:0] lut_c;
    wire [95:0] ymin_c;
    wire [95:0] ymax_c;

    genvar gl;
    generate
        for (gl = 0; gl < 3; gl = gl + 1) begin : g_lut
            wire [31:0] ctl  = cfg_q[`TLM_IX_LCTL + gl];
            // [RULE2] axis kind
            wire        tmode = ctl[0];
            wire [31:0] inp  = src_v[ctl[7:4]];
            reg  [31:0] ms_q;
            reg  signed [31:0] x;
            reg  signed [31:0] yo;
            reg  signed [31:0] ymn;
            reg  signed [31:0] ymx;
            reg  signed [31:0] xp;
            reg  signed [31:0] xq;
            reg  signed [31:0] yp;
            reg  signed [31:0] yq;
            reg  signed [63:0] num;
            reg  [1:0]  sh;
            reg         stop;
            reg         done;
            integer     p;

            // [RULE3] ms counter runs while input enables
            always @(posedge aclk) begin
                if (!aresetn)
                    ms_q <= 32'h0;
                else if (!tmode || inp == 32'h0)
                    ms_q <= 32'h0;
                else if (tick && ms_q != 32'hffffffff)
                    ms_q <= ms_q + 32'h1;
            end

            always @* begin
                x    = tmode ? $signed(ms_q) : $signed(inp);
                xq   = $signed(cfg_q[gl*11]);
                yq   = $signed(cfg_q[IX_Y + gl*11]);
                yo   = yq;
                ymn  = yq;
                ymx  = yq;
                stop = 1'b0;
                done = (x <= xq);
                xp   = xq;
                yp   = yq;
                sh   = `TLM_SH_JUMP;
                num  = 64'sh0;
                // [RULE1] walk eleven points
                for (p = 1; p < `TLM_NPT; p = p + 1) begin
                    sh = cfg_q[IX_SH + gl*11 + p][1:0];
                    // [RULE7] ignore this and later
                    if (sh == `TLM_SH_IGN)
                        stop = 1'b1;
                    if (!stop) begin
                        xp = xq;
                        yp = yq;
                        xq = $signed(cfg_q[IX_X + gl*11 + p]);
                        yq = $signed(cfg_q[IX_Y + gl*11 + p]);
                        // [RULE10] range of live points
                        if (yq < ymn)
                            ymn = yq;
                        if (yq > ymx)
                            ymx = yq;
                        if (!done) begin
                            yo = yq;
                            if (x <= xq) begin
                                done = 1'b1;
                                // [RULE4] ramp interpolates
                                if (sh == `TLM_SH_RAMP && xq != xp) begin
                                    num = (yq - yp) * (x - xp);
                                    num = num / (xq - xp);
                                    yo  = yp + num[31:0];
                                end
                                // [RULE5] jump keeps yq
                            end
                        end
                    end
                end
            end

            assign lut_c[32*gl +: 32]  = yo;
            assign ymin_c[32*gl +: 32] = ymn;
            assign ymax_c[32*gl +: 32] = ymx;
        end
    endgenerate

    // Table selector
    reg  [31:0] sel_c;
    reg  [31:0] cand;
    reg  [31:0] cnd;
    reg  [2:0]  cr;
    reg  [1:0]  tab;
    reg         sat;
    integer     ci;
    integer     cj;

    always @* begin
        cand  = cfg_q[`TLM_IX_CAND];
        tab   = (cand[5:4] == 2'h3) ? 2'h0 : cand[5:4];
        sel_c = lut_c[32*tab +: 32];
        cnd   = 32'h0;
        cr    = 3'h0;
        sat   = 1'b0;
        // [RULE15] reverse walk so the first candidate wins
        for (ci = 2; ci >= 0; ci = ci - 1) begin
            cand = cfg_q[`TLM_IX_CAND + ci];
            for (cj = 0; cj < 3; cj = cj + 1) begin
                cnd = cfg_q[`TLM_IX_COND + ci*3 + cj];
                // [RULE12] relation per condition
                cr[cj] = cmp_rel(cnd[2:0], src_v[cnd[7:4]], src_v[cnd[11:8]]);
            end
            // [RULE14] combine code
            case (cand[2:0])
                3'h0:    sat = 1'b1;
                3'h1:    sat = &cr;
                3'h2:    sat = |cr;
                3'h3:    sat = (cr[0] & cr[1]) | cr[2];
                3'h4:    sat = (cr[0] | cr[1]) & cr[2];
                default: sat = 1'b0;
            endcase
            tab = (cand[5:4] == 2'h3) ? 2'h0 : cand[5:4];
            if (sat)
                sel_c = lut_c[32*tab +: 32];
        end
    end

    // Math input scaling
    wire [191:0] pct;
    genvar gm;
    generate
        for (gm = 0; gm < 6; gm = gm + 1) begin : g_pct
            wire signed [31:0] mn = cfg_q[`TLM_IX_MMIN + gm];
            wire signed [31:0] mx = cfg_q[`TLM_IX_MMAX + gm];
            wire signed [31:0] v  = src_v[cfg_q[`TLM_IX_MSRC + gm][3:0]];
            wire signed [63:0] sc = ((v - mn) * FS) / ((mx == mn) ? 32'sh1 : (mx - mn));
            // [RULE16] percent of min..max
            assign pct[32*gm +: 32] = (mx == mn) ? 32'h0 : clamp_fs(sc);
        end
    endgenerate

    reg  signed [31:0] acc;
    reg  signed [31:0] ob;
    reg  signed [63:0] wide;
    reg  signed [31:0] olo;
    reg  signed [31:0] ohi;
    reg  [31:0] stg;
    reg  [31:0] math_c;
    reg  [2:0]  bsel;
    reg         la;
    reg         lb;
    integer     si;

    always @* begin
        bsel = cfg_q[`TLM_IX_A1][2:0];
        acc  = (bsel == 3'h0 || bsel > 3'h6) ? 32'sh0 : $signed(pct[32*(bsel-3'h1) +: 32]);
        ob   = 32'sh0;
        wide = 64'sh0;
        stg  = 32'h0;
        la   = 1'b0;
        lb   = 1'b0;
        // [RULE17] four chained stages
        for (si = 0; si < 4; si = si + 1) begin
            stg  = cfg_q[`TLM_IX_STG + si];
            bsel = stg[6:4];
            // [RULE18] unused right operand
            if (bsel != 3'h0 && bsel <= 3'h6) begin
                ob = $signed(pct[32*(bsel-3'h1) +: 32]);
                // [RULE20] logic truth threshold
                la = (acc >= ONE);
                lb = (ob >= ONE);
                // [RULE19] operator decode
                case (stg[3:0])
                    `TLM_OP_OR:  wide = (la | lb) ? ONE : 32'sh0;
                    `TLM_OP_AND: wide = (la & lb) ? ONE : 32'sh0;
                    `TLM_OP_XOR: wide = (la ^ lb) ? ONE : 32'sh0;
                    `TLM_OP_ADD: wide = acc + ob;
                    `TLM_OP_SUB: wide = acc - ob;
                    `TLM_OP_MUL: wide = (acc * ob) / FS;
                    // [RULE21] zero divisor
                    `TLM_OP_DIV: wide = (ob == 0) ? FS : (acc * FS) / ob;
                    `TLM_OP_MIN: wide = (acc < ob) ? acc : ob;
                    `TLM_OP_MAX: wide = (acc > ob) ? acc : ob;
                    default: begin
                        if (stg[3:0] < 4'h6)
                            wide = cmp_rel(stg[2:0], acc, ob) ? ONE : 32'sh0;
                        else
                            wide = acc;
                    end
                endcase
                // [RULE23] clamp each stage
                acc = clamp_fs(wide);
            end
        end
        // [RULE22] map onto output range
        olo    = cfg_q[`TLM_IX_OLO];
        ohi    = cfg_q[`TLM_IX_OHI];
        wide   = ((ohi - olo) * acc) / FS;
        math_c = olo + wide[31:0];
    end

    // [RULE24] all results taken on the tick
    always @(posedge aclk) begin
        if (!aresetn) begin
            lut_value_q  <= 96'h0;
            sel_value_q  <= 32'h0;
            math_value_q <= 32'h0;
            update_q     <= 1'b0;
        end else begin
            update_q <= tick;
            if (tick) begin
                lut_value_q  <= lut_c;
                // [RULE11] output only while enabled
                sel_value_q  <= cfg_q[`TLM_IX_SEN][0] ? sel_c : 32'h0;
                math_value_q <= math_c;
            end
        end
    end

    // AXI write path
    reg  [7:0]  aw_idx_q;
    reg  [31:0] w_data_q;
    reg  [3:0]  w_strb_q;
    reg  [31:0] wv;
    reg  signed [31:0] blo;
    reg  signed [31:0] bhi;
    reg  [7:0]  rel;
    reg  [1:0]  tix;
    integer     bi;

    always @* begin
        wv = cfg_q[(aw_idx_q < NCFG) ? aw_idx_q : 8'h0];
        for (bi = 0; bi < 4; bi = bi + 1) begin
            if (w_strb_q[bi])
                wv[8*bi +: 8] = w_data_q[8*bi +: 8];
        end
        rel = aw_idx_q - IX_X;
        tix = (rel >= 8'd22) ? 2'h2 : ((rel >= 8'd11) ? 2'h1 : 2'h0);
        blo = XMIN;
        bhi = XMAX;
        // [RULE8] bounds from math range
        if (cfg_q[`TLM_IX_LCTL + tix][7:4] == `TLM_SRC_MATH) begin
            blo = cfg_q[`TLM_IX_OLO];
            bhi = cfg_q[`TLM_IX_OHI];
            if (blo > bhi) begin
                blo = cfg_q[`TLM_IX_OHI];
                bhi = cfg_q[`TLM_IX_OLO];
            end
        end
        if (aw_idx_q < IX_Y) begin
            if ($signed(wv) < blo)
                wv = blo;
            else if ($signed(wv) > bhi)
                wv = bhi;
        end
        // [RULE6] point 0 stays jump
        if (aw_idx_q == IX_SH || aw_idx_q == IX_SH + 8'd11 || aw_idx_q == IX_SH + 8'd22)
            wv = {30'h0, `TLM_SH_JUMP};
    end

    integer ri;
    always @(posedge aclk) begin
        if (!aresetn) begin
            for (ri = 0; ri < `TLM_NCFG; ri = ri + 1)
                cfg_q[ri] <= 32'h0;
            cfg_q[`TLM_IX_SH]      <= {30'h0, `TLM_SH_JUMP};
            cfg_q[`TLM_IX_SH + 11] <= {30'h0, `TLM_SH_JUMP};
            cfg_q[`TLM_IX_SH + 22] <= {30'h0, `TLM_SH_JUMP};
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `TLM_RESP_OK;
            aw_idx_q      <= 8'h0;
            w_data_q      <= 32'h0;
            w_strb_q      <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_idx_q      <= s_axi_awaddr[9:2];
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data_q     <= s_axi_wdata;
                w_strb_q     <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (!s_axi_awready && !s_axi_wready && !s_axi_bvalid) begin
                if (aw_idx_q < NCFG) begin
                    cfg_q[aw_idx_q] <= wv;
                    s_axi_bresp     <= `TLM_RESP_OK;
                end else begin
                    s_axi_bresp <= `TLM_RESP_ERR;
                end
                s_axi_bvalid  <= 1'b1;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
            if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // AXI read path; status words show live results
    reg  [31:0] rd_v;
    reg  [7:0]  ridx;
    reg  [7:0]  roff;
    always @* begin
        ridx = s_axi_araddr[9:2];
        roff = 8'h0;
        rd_v = 32'h0;
        if (ridx < NCFG) begin
            rd_v = cfg_q[ridx];
        end else if (ridx < `TLM_IX_SOUT) begin
            roff = ridx - `TLM_IX_LOUT;
            rd_v = lut_value_q[32*roff[1:0] +: 32];
        end else if (ridx == `TLM_IX_SOUT) begin
            rd_v = sel_value_q;
        end else if (ridx == `TLM_IX_MOUT) begin
            rd_v = math_value_q;
        end else if (ridx < `TLM_IX_YMAX) begin
            roff = ridx - `TLM_IX_YMIN;
            rd_v = ymin_c[32*roff[1:0] +: 32];
        end else if (ridx < NREG) begin
            roff = ridx - `TLM_IX_YMAX;
            rd_v = ymax_c[32*roff[1:0] +: 32];
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= `TLM_RESP_OK;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rdata   <= rd_v;
                s_axi_rresp   <= (ridx < NREG) ? `TLM_RESP_OK : `TLM_RESP_ERR;
                s_axi_rvalid  <= 1'b1;
                s_axi_arready <= 1'b0;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

endmodule

/* File: sim/tlm_core_sva.sv */
// Checker for the table, logic and math compute block.
// Assumes only the top module's ports and one clock domain.
`timescale 1ns/10ps
module tlm_chk #(
    parameter TICK_CYC = 20000
) (
    // Clock and reset
    input wire        aclk,
    input wire        aresetn,
    // Write channels
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    // Read channels
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    // Results
    input wire [95:0] lut_value_q,
    input wire [31:0] sel_value_q,
    input wire [31:0] math_value_q,
    input wire        update_q
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_UPD_GAP: assert property (update_q |=> !update_q [*6])
        else $error("update pulses too close");
    AST_LUT_UPD: assert property ($past(aresetn) && !$stable(lut_value_q) |-> update_q)
        else $error("table result moved without update");
    AST_SEL_UPD: assert property ($past(aresetn) && !$stable(sel_value_q) |-> update_q)
        else $error("selector result moved without update");
    AST_MATH_UPD: assert property ($past(aresetn) && !$stable(math_value_q) |-> update_q)
        else $error("math result moved without update");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    AST_W_ANS: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write not answered");
    AST_R_ANS: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
endmodule

bind tlm_core tlm_chk #(.TICK_CYC(TICK_CYC)) chk_u (.*);

/* File: sim/tlm_src_model.sv */
// Stand-in for the function blocks that feed the signal inputs.
// Assumes the bench sets one signal word per clock.
`timescale 1ns/10ps
module tlm_src_model (
    // Clock and reset
    input  wire         aclk,
    input  wire         aresetn,
    // Bench control
    input  wire         set_en,
    input  wire [2:0]   set_idx,
    input  wire [31:0]  set_val,
    // Signal words
    output reg  [255:0] sig_q
);
    always @(posedge aclk) begin
        if (!aresetn) begin
            sig_q <= 256'h0;
        end else if (set_en) begin
            sig_q[32*set_idx +: 32] <= set_val;
        end
    end
endmodule

/* File: sim/table_logic_math_compute_bench.sv */
// Self-checking bench for the compute block.
// Assumes a short tick so that many ticks fit in one run.
`timescale 1ns/10ps
`include "tlm_map.vh"
module table_logic_math_compute_bench;
    reg          aclk = 1'b0, aresetn = 1'b0, set_en = 1'b0;
    reg  [9:0]   awaddr = 10'h0, araddr = 10'h0;
    reg  [31:0]  wdata = 32'h0, set_val = 32'h0, rq;
    reg          awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    reg  [2:0]   set_idx = 3'h0;
    reg  [1:0]   rs;
    wire         awready, wready, bvalid, arready, rvalid, update_q;
    wire [1:0]   bresp, rresp;
    wire [31:0]  rdata, sel_value_q, math_value_q;
    wire [95:0]  lut_value_q;
    wire [255:0] sig_in;
    integer      n_fail = 0, samples_checked = 0, cyc = 0, k;
    localparam logic [39:0] CFG [0:26] = '{40'h6300000010, 40'h2100000064, 40'h030000012c, 40'h02000000c8,
        40'h0100000064, 40'h220000012c, 40'h4300000001, 40'h23000003e8, 40'h4400000002, 40'h24ffffec78,
        40'h4600000001, 40'h2500002710, 40'h2c00000309, 40'h370000022b, 40'h6600000001, 40'h6700000011,
        40'h6800000020, 40'h6a00000022, 40'h7300000001, 40'h7400000003, 40'h7f000003e8, 40'h80000003e8,
        40'h8500000029, 40'h8900000001, 40'h8a000003e8, 40'h8b00000bb8, 40'h6500000000};
    localparam logic [31:0] TSIG [0:3] = '{32'h32, 32'h96, 32'h1f4, 32'hfffffff6};
    localparam logic [31:0] TEXP [0:3] = '{32'hc8, 32'h3e8, 32'h3e8, 32'h64};
    localparam logic [31:0] MSIG [0:4] = '{32'h12c, 32'h12c, 32'h12c, 32'h12c, 32'h384};
    localparam logic [31:0] MOP  [0:4] = '{32'h3c, 32'h2a, 32'h27, 32'h0, 32'h2a};
    localparam logic [31:0] MEXP [0:4] = '{32'hbb8, 32'h640, 32'h3fc, 32'h7d0, 32'ha28};

    tlm_core #(.TICK_CYC(8)) dut_u (.aclk, .aresetn, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sig_in, .lut_value_q,
        .sel_value_q, .math_value_q, .update_q);
    tlm_src_model src_u (.aclk, .aresetn, .set_en, .set_idx, .set_val, .sig_q(sig_in));

    always #25 aclk = ~aclk;
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail = n_fail + 1;
            end_of_test;
        end
    end

    task end_of_test;
        begin
            $display("Checks %0d, mismatches %0d", samples_checked, n_fail);
            if (n_fail == 0 && samples_checked > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask

    task chk(input [31:0] g, input [31:0] e);
        begin
            samples_checked = samples_checked + 1;
            if (g !== e) begin
                n_fail = n_fail + 1;
                $display("Error at %0t ns: got %h expected %h", $time, g, e);
            end
        end
    endtask

    task xfer(input w, input [7:0] i, input [31:0] d);
        reg a, b, r, dn;
        begin
            @(posedge aclk);
            {awaddr, araddr, wdata} <= {i, 2'h0, i, 2'h0, d};
            {awvalid, wvalid, arvalid, bready, rready} <= {w, w, !w, w, !w};
            dn = 1'b0;
            while (!dn) begin
                @(negedge aclk);
                {a, b, r, dn} = {awready, wready, arready, w ? bvalid : rvalid};
                rq = rdata;
                rs = w ? bresp : rresp;
                @(posedge aclk);
                if (a) awvalid <= 1'b0;
                if (b) wvalid <= 1'b0;
                if (r) arvalid <= 1'b0;
            end
            {bready, rready} <= 2'h0;
        end
    endtask

    task sg(input [2:0] i, input [31:0] v);
        begin
            @(posedge aclk);
            set_en <= 1'b1;
            set_idx <= i;
            set_val <= v;
            @(posedge aclk);
            set_en <= 1'b0;
        end
    endtask

    task tk(input integer n);
        begin
            repeat (n) begin
                @(negedge aclk);
                while (update_q !== 1'b1) @(negedge aclk);
            end
        end
    endtask

    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        xfer(0, 8'h42, 32'h0);
        chk(rq, 32'h2);
        xfer(1, 8'h42, 32'h1);
        xfer(0, 8'h42, 32'h0);
        chk(rq, 32'h2);
        xfer(0, 8'h66, 32'h0);
        chk(rq, 32'h0);
        xfer(0, 8'hc8, 32'h0);
        chk({30'h0, rs}, {30'h0, `TLM_RESP_ERR});
        xfer(1, 8'h8c, 32'h1);
        chk({30'h0, rs}, {30'h0, `TLM_RESP_ERR});
        xfer(1, 8'h0b, 32'h1e8480);
        xfer(0, 8'h0b, 32'h0);
        chk(rq, 32'hf4240);
        xfer(1, 8'h0b, 32'hfffcf2c0);
        xfer(0, 8'h0b, 32'h0);
        chk(rq, 32'hfffe7960);
        $display("Reset and bus test done");
        for (k = 0; k < 27; k = k + 1) xfer(1, CFG[k][39:32], CFG[k][31:0]);
        for (k = 0; k < 4; k = k + 1) begin
            sg(3'h0, TSIG[k]);
            tk(2);
            chk(lut_value_q[31:0], TEXP[k]);
        end
        xfer(0, 8'h91, 32'h0);
        chk(rq, 32'h64);
        xfer(0, 8'h94, 32'h0);
        chk(rq, 32'h3e8);
        $display("Lookup table test done");
        sg(3'h1, 32'h5);
        for (k = 0; k < 6; k = k + 1) begin
            xfer(1, 8'h6a, 32'h20 | k);
            tk(3);
            chk(sel_value_q, ((32'he >> k) & 1) ? 32'h309 : 32'h22b);
        end
        xfer(1, 8'h6a, 32'h20);
        xfer(1, 8'h6c, 32'h1);
        for (k = 0; k < 5; k = k + 1) begin
            xfer(1, 8'h67, 32'h10 | k);
            tk(3);
            chk(sel_value_q, ((32'h5 >> k) & 1) ? 32'h309 : 32'h22b);
        end
        $display("Selector test done");
        xfer(1, 8'h65, 32'h41);
        xfer(1, 8'h17, 32'h4);
        xfer(1, 8'h38, 32'h3bb);
        xfer(1, 8'h59, 32'h2);
        sg(3'h3, 32'h0);
        tk(3);
        chk(lut_value_q[95:64], 32'h22b);
        sg(3'h3, 32'h3e8);
        tk(8);
        chk(lut_value_q[95:64], 32'h3bb);
        $display("Time mode test done");
        sg(3'h2, 32'hc8);
        for (k = 0; k < 5; k = k + 1) begin
            sg(3'h0, MSIG[k]);
            xfer(1, 8'h86, MOP[k]);
            tk(2);
            chk(math_value_q, MEXP[k]);
        end
        $display("Math test done");
        end_of_test;
    end
endmodule
